// *** core/upos_pkg.sv ***
// Package: register map, field positions and timing of the USB power/OTG status block
package upos_pkg;

    // APB geometry
    localparam int          APB_AW          = 8;        // Byte address bits decoded
    localparam int          APB_DW          = 32;       // Data width

    // Register byte addresses
    localparam logic [7:0]  OFS_OTG_STAT    = 8'h00;    // otg_cable_session_status
    localparam logic [7:0]  OFS_PWR_CTRL    = 8'h04;    // usb_power_control
    localparam logic [7:0]  OFS_IRQ_STAT    = 8'h08;    // Sticky event status, read-only
    localparam logic [7:0]  OFS_IRQ_EN      = 8'h0c;    // Event enable, read/write
    localparam logic [7:0]  OFS_IRQ_CLR     = 8'h10;    // Event clear, write-only

    // otg_cable_session_status fields
    localparam int          BIT_CABLE_ID    = 7;        // cable_identity_state
    localparam int          BIT_LINE_STABLE = 5;        // line_state_stable
    localparam int          BIT_SESS_VALID  = 3;        // session_valid_flag
    localparam int          BIT_B_SESS_END  = 2;        // b_session_ended
    localparam int          BIT_A_VBUS_OK   = 0;        // a_bus_power_valid

    // usb_power_control fields
    localparam int          BIT_ACT_PEND    = 7;        // activity_pending_flag
    localparam int          BIT_SLEEP_GUARD = 4;        // sleep_entry_guard
    localparam int          BIT_BUSY        = 3;        // controller_busy_flag
    localparam int          BIT_SUSPEND     = 1;        // suspend_control
    localparam int          BIT_POWER_EN    = 0;        // controller_power_enable

    // Event status layout (status, enable and clear share it)
    localparam int          IRQ_W           = 4;        // Number of event bits
    localparam int          EV_ID_CHANGE    = 0;        // Identity pin toggled
    localparam int          EV_LINE_STABLE  = 1;        // Line state became stable
    localparam int          EV_SESS_CHANGE  = 2;        // Session valid toggled
    localparam int          EV_ACTIVITY     = 3;        // Pending activity delivered

    // Reset values
    localparam logic [IRQ_W-1:0] IRQ_RST    = 4'h0;     // Events clear, all masked
    localparam logic        CTRL_RST        = 1'b0;     // Control bits off

    // Pin synchroniser bundle positions
    localparam int          PIN_W           = 7;        // Number of synchronised pins
    localparam int          PIN_ID          = 0;        // Identity pin
    localparam int          PIN_SE0         = 1;        // Single-ended zero
    localparam int          PIN_J_STATE_INDICATION      = 2;        // j_state_indication
    localparam int          PIN_SESS_VALID  = 3;        // Session valid comparator
    localparam int          PIN_B_SESS_END  = 4;        // B session end comparator
    localparam int          PIN_A_VBUS_OK   = 5;        // A VBUS valid comparator
    localparam int          PIN_ACTIVITY    = 6;        // Bus activity detector

    // Timing
    localparam int          CLK_PERIOD_NS   = 100;      // Core clock period
    localparam int          LINE_STABLE_NS  = 1000000;  // Stable window, 1 ms
    localparam int          LINE_STABLE_CYC = LINE_STABLE_NS / CLK_PERIOD_NS;
    localparam int          SHUTDOWN_CYC    = 8;        // Busy tail after disable

endpackage

// *** core/upos_sync.sv ***
// Two flip-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/100ps
module upos_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk_in,
    input  wire logic         reset_in,
    // Asynchronous pins and their synchronised copy
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta;     // First stage, read only by the second

    // Two stages, no logic between them
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// *** core/upos_top.sv ***
// USB power control and OTG cable/session status block with APB slave
`timescale 1ns/100ps
module upos_top
    import upos_pkg::*;
#(
    parameter int MS_CYCLES    = upos_pkg::LINE_STABLE_CYC,
    parameter int OFF_CYCLES   = upos_pkg::SHUTDOWN_CYC
) (
    // Clock and reset
    input  wire logic                       core_clk_in,
    input  wire logic                       reset_in,
    // APB slave
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [upos_pkg::APB_AW-1:0] paddr_in,
    input  wire logic [upos_pkg::APB_DW-1:0] pwdata_in,
    output logic                            pready_out,
    output logic      [upos_pkg::APB_DW-1:0] prdata_out,
    output logic                            pslverr_out,
    // Cable, transceiver and comparator pins
    input  wire logic                       cable_id_in,
    input  wire logic                       line_se0_in,
    input  wire logic                       j_state_indication_in,
    input  wire logic                       vbus_sess_valid_in,
    input  wire logic                       vbus_b_sess_end_in,
    input  wire logic                       vbus_a_valid_in,
    input  wire logic                       bus_activity_in,
    // Power and clock controls
    output logic                            usb_clk_enable_out,
    output logic                            xcvr_low_power_out,
    output logic                            usb_pins_owned_out,
    output logic                            analog_enable_out,
    output logic                            sleep_block_out,
    // Interrupt
    output logic                            irq_out
);
    import upos_pkg::*;

    // Counter widths
    localparam int MS_W  = $clog2(MS_CYCLES + 1);
    localparam int OFF_W = $clog2(OFF_CYCLES + 1);
    localparam logic [MS_W-1:0]  MS_LAST  = MS_W'(MS_CYCLES - 1);
    localparam logic [OFF_W-1:0] OFF_LOAD = OFF_W'(OFF_CYCLES);

    // Synchronised pins
    logic [PIN_W-1:0] pin_raw;      // Pin bundle as it arrives
    logic [PIN_W-1:0] pin_s;        // Pin bundle after two flops
    logic [PIN_W-1:0] pin_d;        // One cycle older copy for edges

    // Line stability
    logic [MS_W-1:0]  ms_cnt;       // Cycles since last line change
    logic             line_change;  // SE0 or J differs from last cycle
    logic             line_stable;  // line_state_stable

    // Control bits
    logic             power_en;     // controller_power_enable
    logic             suspend;      // suspend_control
    logic             sleep_guard;  // sleep_entry_guard
    logic             act_pending;  // activity_pending_flag
    logic [OFF_W-1:0] off_cnt;      // Shutdown tail counter
    logic             busy;         // controller_busy_flag

    // Interrupt registers
    logic [IRQ_W-1:0] irq_stat;     // Sticky events
    logic [IRQ_W-1:0] irq_en;       // Event mask
    logic [IRQ_W-1:0] ev_set;       // Events this cycle

    // APB decode
    logic             acc_phase;    // Access phase cycle
    logic             wr_go;        // Write takes effect now
    logic             wr_go_c;      // Copy of the write strobe, already gated by pready
    logic [APB_DW-1:0] rd_mux;      // Read data for the address
    logic             addr_hit;     // Address maps to a register
    logic [IRQ_W-1:0] clr_req;      // Clear strobes from software
    logic             activity_rise; // Synchronised activity edge
    logic             deliver;      // Pending activity handed on

    assign pin_raw[PIN_ID]         = cable_id_in;
    assign pin_raw[PIN_SE0]        = line_se0_in;
    assign pin_raw[PIN_J_STATE_INDICATION]     = j_state_indication_in;
    assign pin_raw[PIN_SESS_VALID] = vbus_sess_valid_in;
    assign pin_raw[PIN_B_SESS_END] = vbus_b_sess_end_in;
    assign pin_raw[PIN_A_VBUS_OK]  = vbus_a_valid_in;
    assign pin_raw[PIN_ACTIVITY]   = bus_activity_in;

    // All pins cross into the core clock here
    upos_sync #(
        .W          (PIN_W)
    ) u_pin_sync (
        .core_clk_in(core_clk_in),
        .reset_in   (reset_in),
        .async_in   (pin_raw),
        .sync_out   (pin_s)
    );

    // Delayed copy for change detection, reads only the second stage
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pin_d <= '0;
        end else begin
            pin_d <= pin_s;
        end
    end

    // Line change and activity edges
    assign line_change   = (pin_s[PIN_SE0] != pin_d[PIN_SE0]) ||
                           (pin_s[PIN_J_STATE_INDICATION] != pin_d[PIN_J_STATE_INDICATION]);
    assign activity_rise = pin_s[PIN_ACTIVITY] & ~pin_d[PIN_ACTIVITY];

    // Millisecond timer, held at the top once the window is complete
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ms_cnt <= '0;
        end else if (line_change) begin
            ms_cnt <= '0;
        end else if (ms_cnt != MS_LAST) begin
            ms_cnt <= ms_cnt + 1'b1;
        end
    end

    // Stable flag drops at once on a change, rises at the millisecond tick
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            line_stable <= 1'b0;
        end else if (line_change) begin
            line_stable <= 1'b0;
        end else if (ms_cnt == MS_LAST) begin
            line_stable <= 1'b1;
        end
    end

    // APB phase decode; writes land only at the edge where pready is seen
    assign acc_phase = psel_in & penable_in;
    assign wr_go     = acc_phase & pready_out & pwrite_in & addr_hit;
    assign wr_go_c   = wr_go;

    // Address decode for every mapped word
    always_comb begin
        case (paddr_in)
            OFS_OTG_STAT, OFS_PWR_CTRL, OFS_IRQ_STAT,
            OFS_IRQ_EN, OFS_IRQ_CLR: begin
                addr_hit = 1'b1;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Software writable power control bits
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            power_en    <= CTRL_RST;
            suspend     <= CTRL_RST;
            sleep_guard <= CTRL_RST;
        end else if (wr_go_c && paddr_in == OFS_PWR_CTRL) begin
            power_en    <= pwdata_in[BIT_POWER_EN];
            suspend     <= pwdata_in[BIT_SUSPEND];
            sleep_guard <= pwdata_in[BIT_SLEEP_GUARD];
        end
    end

    // Shutdown tail: busy lingers after disable; nothing holds off a quick re-enable
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            off_cnt <= '0;
        end else if (power_en) begin
            off_cnt <= OFF_LOAD;
        end else if (off_cnt != '0) begin
            off_cnt <= off_cnt - 1'b1;
        end
    end

    assign busy = power_en | (off_cnt != '0);

    // Activity while suspended waits for the clock to come back
    assign deliver = act_pending & power_en & ~suspend;

    // Pending activity flag; a new activity edge beats delivery
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            act_pending <= 1'b0;
        end else if (activity_rise && power_en && suspend) begin
            act_pending <= 1'b1;
        end else if (deliver || !power_en) begin
            act_pending <= 1'b0;
        end
    end

    // Events feeding the sticky status
    always_comb begin
        ev_set                 = '0;
        ev_set[EV_ID_CHANGE]   = pin_s[PIN_ID] ^ pin_d[PIN_ID];
        ev_set[EV_LINE_STABLE] = ~line_stable & ~line_change & (ms_cnt == MS_LAST);
        ev_set[EV_SESS_CHANGE] = pin_s[PIN_SESS_VALID] ^ pin_d[PIN_SESS_VALID];
        ev_set[EV_ACTIVITY]    = deliver;
    end

    // Clear strobes from the write-only clear word
    assign clr_req = (wr_go_c && paddr_in == OFS_IRQ_CLR) ? pwdata_in[IRQ_W-1:0] : '0;

    // Sticky status: an event in the clearing cycle survives
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            irq_stat <= IRQ_RST;
        end else begin
            irq_stat <= (irq_stat & ~clr_req) | ev_set;
        end
    end

    // Interrupt enable mask
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            irq_en <= IRQ_RST;
        end else if (wr_go_c && paddr_in == OFS_IRQ_EN) begin
            irq_en <= pwdata_in[IRQ_W-1:0];
        end
    end

    // Level interrupt, registered
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat & irq_en);
        end
    end

    // Read multiplexer; unlisted bits stay zero
    always_comb begin
        rd_mux = '0;
        case (paddr_in)
            OFS_OTG_STAT: begin
                rd_mux[BIT_CABLE_ID]    = pin_s[PIN_ID];
                rd_mux[BIT_LINE_STABLE] = line_stable;
                rd_mux[BIT_SESS_VALID]  = pin_s[PIN_SESS_VALID];
                rd_mux[BIT_B_SESS_END]  = pin_s[PIN_B_SESS_END];
                rd_mux[BIT_A_VBUS_OK]   = pin_s[PIN_A_VBUS_OK];
            end
            OFS_PWR_CTRL: begin
                rd_mux[BIT_ACT_PEND]    = act_pending;
                rd_mux[BIT_SLEEP_GUARD] = sleep_guard;
                rd_mux[BIT_BUSY]        = busy;
                rd_mux[BIT_SUSPEND]     = suspend;
                rd_mux[BIT_POWER_EN]    = power_en;
            end
            OFS_IRQ_STAT: begin
                rd_mux[IRQ_W-1:0] = irq_stat;
            end
            OFS_IRQ_EN: begin
                rd_mux[IRQ_W-1:0] = irq_en;
            end
            default: begin
                // Clear word and unmapped addresses read zero
                rd_mux = '0;
            end
        endcase
    end

    // APB answer: one wait state, pready pulses for one cycle
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end else if (acc_phase && !pready_out) begin
            pready_out  <= 1'b1;
            pslverr_out <= ~addr_hit;
            prdata_out  <= pwrite_in ? '0 : rd_mux;
        end else begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end
    end

    // Clock gate and transceiver power, registered so no glitch reaches them
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            usb_clk_enable_out <= 1'b0;
            xcvr_low_power_out <= 1'b1;
        end else begin
            usb_clk_enable_out <= power_en & ~suspend;
            xcvr_low_power_out <= suspend | ~power_en;
        end
    end

    // Pin ownership and analog enable follow power
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            usb_pins_owned_out <= 1'b0;
            analog_enable_out  <= 1'b0;
        end else begin
            usb_pins_owned_out <= power_en;
            analog_enable_out  <= power_en;
        end
    end

    // Sleep guard; live activity or a pending one both hold off sleep
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sleep_block_out <= 1'b0;
        end else begin
            sleep_block_out <= sleep_guard & (pin_s[PIN_ACTIVITY] | act_pending);
        end
    end

endmodule

// *** verif/upos_chk.sv ***
// Port-level checker for the USB power/OTG status block
`timescale 1ns/100ps
module upos_chk
    import upos_pkg::*;
#(
    parameter int MS_CYCLES = LINE_STABLE_CYC
) (
    // Clock, reset and APB
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic        pready_out,
    input  wire logic [31:0] prdata_out,
    input  wire logic        pslverr_out,
    // Line pins and power controls
    input  wire logic        line_se0_in,
    input  wire logic        j_state_indication_in,
    input  wire logic        usb_clk_enable_out,
    input  wire logic        xcvr_low_power_out,
    input  wire logic        usb_pins_owned_out,
    input  wire logic        analog_enable_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    logic rd_ok;                   // Read completing this cycle
    logic wr_ok;                   // Write completing this cycle
    logic se0_q;                   // Previous se0 pin
    logic j_q;                     // Previous J pin
    int   quiet;                   // Cycles since the line pins last moved
    assign rd_ok = psel_in && penable_in && pready_out && !pwrite_in;
    assign wr_ok = psel_in && penable_in && pready_out && pwrite_in;
    // Quiet-time counter; saturates so long runs cannot wrap
    always_ff @(posedge core_clk_in) begin
        se0_q <= line_se0_in;
        j_q   <= j_state_indication_in;
        if (reset_in || se0_q != line_se0_in || j_q != j_state_indication_in) begin
            quiet <= 0;
        end else if (quiet < 100000) begin
            quiet <= quiet + 1;
        end
    end
    chk_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("ready not given after one wait state");
    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    chk_gate_split: assert property (usb_clk_enable_out != xcvr_low_power_out)
        else $error("clock gate and transceiver low power disagree");
    chk_power_pair: assert property ((usb_pins_owned_out == analog_enable_out)
        && (!usb_clk_enable_out || usb_pins_owned_out))
        else $error("power outputs inconsistent");
    chk_upper_zero: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_stat_holes: assert property (rd_ok && paddr_in == OFS_OTG_STAT
        |-> (prdata_out & 32'h0000_0052) == 32'h0)
        else $error("unused status bits not zero");
    chk_busy_power: assert property (rd_ok && paddr_in == OFS_PWR_CTRL
        |-> (prdata_out & 32'h64) == 32'h0 && (!prdata_out[BIT_POWER_EN] || prdata_out[BIT_BUSY]))
        else $error("busy low while powered or hole bit set");
    chk_wr_power: assert property (wr_ok && paddr_in == OFS_PWR_CTRL |-> ##2
        usb_pins_owned_out == $past(pwdata_in[BIT_POWER_EN], 2) && usb_clk_enable_out ==
        ($past(pwdata_in[BIT_POWER_EN], 2) && !$past(pwdata_in[BIT_SUSPEND], 2)))
        else $error("power outputs do not follow control write");
    chk_stable_wait: assert property (rd_ok && paddr_in == OFS_OTG_STAT
        && prdata_out[BIT_LINE_STABLE] |-> quiet >= MS_CYCLES - 2)
        else $error("line stable reported too early");
    chk_err_unmapped: assert property (pready_out && paddr_in > OFS_IRQ_CLR
        |-> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped access not refused");
endmodule
bind upos_top upos_chk #(.MS_CYCLES(MS_CYCLES)) upos_chk_inst (
    .core_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .pready_out, .prdata_out, .pslverr_out, .line_se0_in, .j_state_indication_in,
    .usb_clk_enable_out, .xcvr_low_power_out, .usb_pins_owned_out, .analog_enable_out
);

// *** verif/upos_cable_model.sv ***
// Behavioural cable, transceiver and VBUS comparator model
`timescale 1ns/100ps
module upos_cable_model (
    // Wanted state: id, se0, J, VBUS valid, A role, activity
    input  wire logic [5:0] want_in,
    // Pins towards the block
    output logic            cable_id_out,
    output logic            se0_out,
    output logic            j_state_out,
    output logic            sess_valid_out,
    output logic            b_sess_end_out,
    output logic            a_valid_out,
    output logic            activity_out
);
    // High with no cable or a B plug
    assign cable_id_out   = want_in[0];
    // SE0 pulls both data lines low, so J cannot show with it
    assign se0_out        = want_in[1];
    assign j_state_out    = want_in[2] & ~want_in[1];
    // One VBUS level feeds all comparators, so they never disagree
    assign sess_valid_out = want_in[3];
    assign b_sess_end_out = ~want_in[3];
    assign a_valid_out    = want_in[3] & want_in[4];
    // Raw bus activity detector
    assign activity_out   = want_in[5];
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the USB power/OTG status block
`timescale 1ns/100ps
module testbench;
    import upos_pkg::*;
    localparam int MS = 20;            // Short stable window keeps the run brief
    logic        core_clk_in;          // Core clock
    logic        reset_in;             // Sync reset
    logic        psel_in;              // APB select
    logic        penable_in;           // APB enable
    logic        pwrite_in;            // APB direction
    logic [7:0]  paddr_in;             // APB address
    logic [31:0] pwdata_in;            // APB write data
    logic        pready_out;           // APB ready
    logic [31:0] prdata_out;           // APB read data
    logic        pslverr_out;          // APB error
    logic        irq_out;              // Interrupt
    logic [5:0]  want;                 // Cable state asked of the model
    wire  [6:0]  pin;                  // Model pins
    wire  [4:0]  ctl;                  // Clock, low power, pins, analog, sleep block
    logic [31:0] seed;                 // Xorshift state
    logic [31:0] r;                    // Random draw
    logic [31:0] rd;                   // Last read data
    logic        er;                   // Last error flag
    int          n_errors;             // Mismatches
    int          checks_done;          // Comparisons
    upos_top #(.MS_CYCLES(MS)) upos_top_inst (
        .core_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .pready_out, .prdata_out, .pslverr_out, .cable_id_in(pin[0]), .line_se0_in(pin[1]),
        .j_state_indication_in(pin[2]), .vbus_sess_valid_in(pin[3]),
        .vbus_b_sess_end_in(pin[4]), .vbus_a_valid_in(pin[5]), .bus_activity_in(pin[6]),
        .usb_clk_enable_out(ctl[4]), .xcvr_low_power_out(ctl[3]),
        .usb_pins_owned_out(ctl[2]), .analog_enable_out(ctl[1]),
        .sleep_block_out(ctl[0]), .irq_out
    );
    upos_cable_model upos_cable_model_inst (
        .want_in(want), .cable_id_out(pin[0]), .se0_out(pin[1]), .j_state_out(pin[2]),
        .sess_valid_out(pin[3]), .b_sess_end_out(pin[4]), .a_valid_out(pin[5]),
        .activity_out(pin[6])
    );
    // Free-running core clock, 100 ns
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end
    // Xorshift draw, fixed start for repeatable runs
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected cable status from the pins now shown
    function automatic logic [31:0] stat_exp(input logic stable);
        return {24'h0, pin[0], 1'b0, stable, 1'b0, pin[3], pin[4], 1'b0, pin[5]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    // One APB transfer; ready and the answer are taken at the same rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        // No cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge core_clk_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        // Idle edge so the next setup never reassigns psel in this step
        @(posedge core_clk_in);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // Interrupt and power outputs, sampled mid-cycle
    task automatic outs(input logic [31:0] exp);
        @(negedge core_clk_in);
        check({26'h0, irq_out, ctl}, exp);
        @(posedge core_clk_in);
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        cyc(3000);
        n_errors++;
        give_verdict();
    end
    initial begin
        seed = 32'heac9502d;
        n_errors = 0;
        checks_done = 0;
        reset_in = 1'b1;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        want = 6'h01;
        cyc(6);
        reset_in <= 1'b0;
        cyc(1);
        rdchk(OFS_PWR_CTRL, 32'h0);
        rdchk(OFS_IRQ_EN, 32'h0);
        outs(32'h08);
        // Random cable states; the line flips every time so never settles
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            want <= {1'b0, r[4:2], ~want[1], r[0]};
            cyc(4);
            rdchk(OFS_OTG_STAT, stat_exp(1'b0));
        end
        cyc(MS + 4);
        rdchk(OFS_OTG_STAT, stat_exp(1'b1));
        want <= want ^ 6'h02;
        cyc(MS - 8);
        rdchk(OFS_OTG_STAT, stat_exp(1'b0));
        cyc(MS + 4);
        apb(1'b1, OFS_IRQ_EN, 32'hf);
        apb(1'b1, OFS_IRQ_CLR, 32'hf);
        apb(1'b1, OFS_PWR_CTRL, 32'hffff_ffff);
        rdchk(OFS_PWR_CTRL, 32'h1b);
        outs(32'h0e);
        // Activity while suspended leaves a notification pending
        want <= want | 6'h20;
        cyc(4);
        outs(32'h0f);
        rdchk(OFS_PWR_CTRL, 32'h9b);
        apb(1'b1, OFS_PWR_CTRL, 32'h11);
        rdchk(OFS_IRQ_STAT, 32'h8);
        rdchk(OFS_PWR_CTRL, 32'h19);
        outs(32'h37);
        apb(1'b1, OFS_PWR_CTRL, 32'h01);
        outs(32'h36);
        apb(1'b1, OFS_IRQ_EN, 32'h0);
        outs(32'h16);
        apb(1'b1, OFS_IRQ_EN, 32'hf);
        outs(32'h36);
        apb(1'b1, OFS_IRQ_CLR, 32'h8);
        outs(32'h16);
        want <= want & 6'h1f;
        // no further writes until busy has dropped
        apb(1'b1, OFS_PWR_CTRL, 32'h0);
        rdchk(OFS_PWR_CTRL, 32'h08);
        outs(32'h08);
        cyc(SHUTDOWN_CYC + 2);
        rdchk(OFS_PWR_CTRL, 32'h0);
        apb(1'b1, OFS_OTG_STAT, 32'hffff_ffff);
        rdchk(OFS_OTG_STAT, stat_exp(1'b1));
        // Identity, line and session all move: each raises its own event
        want <= want ^ 6'h0b;
        cyc(MS + 6);
        rdchk(OFS_IRQ_STAT, 32'h7);
        rdchk(OFS_OTG_STAT, stat_exp(1'b1));
        apb(1'b1, 8'h14, 32'hffff_ffff);
        check({31'h0, er}, 32'h1);
        rdchk(8'h14, 32'h0);
        check({31'h0, er}, 32'h1);
        give_verdict();
    end
endmodule
